// file: verilog/axis_sync_monitor.sv
`timescale 1ns/1ps
// Operation
// - Supervise using linearizer deviation, not raw lag
// - Filter only setpoint lag, actual unfiltered
// - Window limit 0..10000, zero disables monitoring
// - Disabled: combined output equals readiness once any held fault is released
// - Clear output on excess while started, ready, no pressure
// - Fault held until next readiness rising edge
// - Start bit low halts profile generator
// - Two selectable process values on bytes 22-25
// - Lag and speed values clamped to 30000
// - Controller signals clamped to 10000
// - Pressure setpoint 0..10000, error +/-10000
// - Integrator upper limit 0..10000
// - Pressure control takes over below position output
// - Integrator lower limit -10000..0
// - Halt off: profile keeps running
// - Halt on: profile paused during intervention
// - Exchange every 6 ms, fast 3 ms
// - Fast rate refuses bus parameterisation
// - Terminal ON overrides linearizer bus bit
module axis_sync_monitor #(
  parameter int WIDTH = 16,
  parameter int NORMAL_CYCLES = axis_sync_pkg::EXCHANGE_NORMAL_CYCLES,
  parameter int FAST_CYCLES = axis_sync_pkg::EXCHANGE_FAST_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ready_in,
  input wire logic start_in,
  input wire logic [15:0] sync_window_limit,
  input wire logic [3:0] filter_shift,
  input wire logic signed [15:0] setpoint_lag_raw,
  input wire logic signed [15:0] actual_lag,
  input wire logic signed [15:0] position_raw,
  input wire logic [15:0] pressure_setpoint_raw,
  input wire logic signed [15:0] pressure_error_raw,
  input wire logic signed [15:0] pressure_p_part,
  input wire logic signed [15:0] pressure_i_part,
  input wire logic signed [15:0] module_raw,
  input wire logic signed [15:0] speed_raw,
  input wire logic [15:0] pressure_integrator_upper_limit,
  input wire logic signed [15:0] pressure_integrator_lower_limit,
  input wire logic profile_halt_on_pressure,
  input wire logic bus_exchange_rate,
  input wire logic linearizer_bus_bit,
  input wire logic linearizer_terminal_on,
  input wire logic param_write_req,
  input wire logic [2:0] extra_bus_signal_select_1,
  input wire logic [2:0] extra_bus_signal_select_2,
  output logic ready_sync_out,
  output logic profile_run,
  output logic pressure_active,
  output logic lag_linearizing_controller,
  output logic signed [15:0] linearizer_deviation,
  output logic signed [15:0] pressure_controller_output,
  output logic [31:0] bus_bytes_22_25,
  output logic exchange_tick,
  output logic param_write_accept,
  output logic param_write_refused
);
  axis_sync_pkg::sync_state_type state_reg, state_next;
  logic signed [23:0] filt_reg;
  logic signed [23:0] filt_next;
  logic ready_d_reg;
  logic ready_rise;
  logic signed [16:0] dev_wide;
  logic [15:0] dev_mag;
  logic [15:0] window_clamped;
  logic [19:0] window_scaled;
  logic excess;
  logic signed [16:0] pressure_sum;
  logic signed [15:0] i_limited;
  logic signed [15:0] upper_s;
  logic signed [15:0] lower_s;
  logic [23:0] tick_count_reg;
  logic [15:0] word_lo, word_hi;
  process_value_if pv ();

  function automatic logic signed [15:0] clamp_signed(input logic signed [16:0] v,
                                                      input logic [15:0] lim);
    logic signed [16:0] l;
    l = $signed({1'b0, lim});
    if (v > l) begin
      clamp_signed = l[15:0];
    end else if (v < -l) begin
      clamp_signed = 16'(-l);
    end else begin
      clamp_signed = v[15:0];
    end
  endfunction

  // First-order lag on setpoint branch only
  always_comb begin
    filt_next = filt_reg + ((($signed({{8{setpoint_lag_raw[15]}}, setpoint_lag_raw}) <<< 8)
      - filt_reg) >>> filter_shift);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_reg <= '0;
    end else begin
      filt_reg <= filt_next;
    end
  end

  // Deviation inside the linearizer, actual unfiltered
  assign dev_wide = 17'($signed(filt_reg[23:8])) - 17'(actual_lag);
  always_ff @(posedge clk) begin
    if (rst) begin
      linearizer_deviation <= '0;
    end else begin
      linearizer_deviation <= clamp_signed(dev_wide, axis_sync_pkg::LAG_LIMIT);
    end
  end

  assign dev_mag = linearizer_deviation[15] ? 16'(-linearizer_deviation)
    : linearizer_deviation;
  // Window limit capped at its range
  assign window_clamped = (sync_window_limit > axis_sync_pkg::SYNC_WINDOW_MAX)
    ? axis_sync_pkg::SYNC_WINDOW_MAX : sync_window_limit;
  assign window_scaled = 20'(window_clamped) * 20'(axis_sync_pkg::WINDOW_SCALE);
  assign excess = 20'(dev_mag) > window_scaled;

  always_ff @(posedge clk) begin
    if (rst) begin
      ready_d_reg <= 1'b0;
    end else begin
      ready_d_reg <= ready_in;
    end
  end
  assign ready_rise = ready_in && !ready_d_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      axis_sync_pkg::SYNC_IDLE: begin
        if (window_clamped != 16'h0000) begin
          state_next = axis_sync_pkg::SYNC_WATCH;
        end
      end
      axis_sync_pkg::SYNC_WATCH: begin
        if (window_clamped == 16'h0000) begin
          state_next = axis_sync_pkg::SYNC_IDLE;
        // Trip only when started, ready, no pressure
        end else if (excess && start_in && ready_in && !pressure_active) begin
          state_next = axis_sync_pkg::SYNC_FAULT;
        end
      end
      axis_sync_pkg::SYNC_FAULT: begin
        // Release only on readiness rising edge
        if (ready_rise) begin
          state_next = axis_sync_pkg::SYNC_WATCH;
        end
      end
      default: state_next = axis_sync_pkg::SYNC_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= axis_sync_pkg::SYNC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ready_sync_out <= 1'b0;
    end else begin
      ready_sync_out <= ready_in && (state_next != axis_sync_pkg::SYNC_FAULT);
    end
  end

  assign upper_s = (pressure_integrator_upper_limit > axis_sync_pkg::PCT_LIMIT)
    ? $signed(axis_sync_pkg::PCT_LIMIT) : $signed(pressure_integrator_upper_limit);
  always_comb begin
    if (pressure_integrator_lower_limit > 16'sh0000) begin
      lower_s = 16'sh0000;
    end else if (pressure_integrator_lower_limit < -$signed(axis_sync_pkg::PCT_LIMIT)) begin
      lower_s = -$signed(axis_sync_pkg::PCT_LIMIT);
    end else begin
      lower_s = pressure_integrator_lower_limit;
    end
  end
  assign i_limited = (pressure_i_part > upper_s) ? upper_s
    : ((pressure_i_part < lower_s) ? lower_s : pressure_i_part);
  assign pressure_sum = 17'(pressure_p_part) + 17'(i_limited);

  always_ff @(posedge clk) begin
    if (rst) begin
      pressure_active <= 1'b0;
      pressure_controller_output <= '0;
    end else begin
      // Takeover when P plus limited I below position
      pressure_active <= pressure_sum < 17'(position_raw);
      // Pressure output clamped to percent range
      pressure_controller_output <= clamp_signed(pressure_sum, axis_sync_pkg::PCT_LIMIT);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      profile_run <= 1'b0;
    end else begin
      profile_run <= start_in && !(profile_halt_on_pressure && pressure_active);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lag_linearizing_controller <= 1'b0;
    end else begin
      // Terminal ON overrides the bus bit
      lag_linearizing_controller <= linearizer_terminal_on || linearizer_bus_bit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_count_reg <= '0;
      exchange_tick <= 1'b0;
    end else if (tick_count_reg >= 24'((bus_exchange_rate ? FAST_CYCLES : NORMAL_CYCLES) - 1))
    begin
      tick_count_reg <= '0;
      exchange_tick <= 1'b1;
    end else begin
      tick_count_reg <= tick_count_reg + 24'h000001;
      exchange_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      param_write_accept <= 1'b0;
      param_write_refused <= 1'b0;
    end else begin
      param_write_accept <= param_write_req && !bus_exchange_rate;
      param_write_refused <= param_write_req && bus_exchange_rate;
    end
  end

  // Lag and speed clamped to 30000
  assign pv.setpoint_lag = clamp_signed(17'(setpoint_lag_raw), axis_sync_pkg::LAG_LIMIT);
  assign pv.linearizer_deviation = linearizer_deviation;
  assign pv.measured_speed = clamp_signed(17'(speed_raw), axis_sync_pkg::LAG_LIMIT);
  assign pv.position_out = clamp_signed(17'(position_raw), axis_sync_pkg::PCT_LIMIT);
  assign pv.pressure_controller_output = pressure_controller_output;
  assign pv.module_out = clamp_signed(17'(module_raw), axis_sync_pkg::PCT_LIMIT);
  assign pv.pressure_setpoint = (pressure_setpoint_raw > axis_sync_pkg::PCT_LIMIT)
    ? axis_sync_pkg::PCT_LIMIT : pressure_setpoint_raw;
  assign pv.pressure_error = clamp_signed(17'(pressure_error_raw), axis_sync_pkg::PCT_LIMIT);

  // Two selected values onto bytes 22-25
  bus_value_mux #(.WIDTH(16)) mux_lo (
    .clk(clk),
    .rst(rst),
    .select(extra_bus_signal_select_1),
    .values(pv),
    .value_reg(word_lo)
  );
  bus_value_mux #(.WIDTH(16)) mux_hi (
    .clk(clk),
    .rst(rst),
    .select(extra_bus_signal_select_2),
    .values(pv),
    .value_reg(word_hi)
  );
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_bytes_22_25 <= '0;
    end else begin
      bus_bytes_22_25 <= {word_hi, word_lo};
    end
  end

  property fault_holds;
    @(posedge clk) disable iff (rst)
    (state_reg == axis_sync_pkg::SYNC_FAULT && !ready_rise) |=> !ready_sync_out;
  endproperty
  fault_hold_a: assert property (fault_holds) else $error("fault released early");
  sequence trip_cond;
    excess && start_in && ready_in && !pressure_active && window_clamped != 16'h0000
      && state_reg == axis_sync_pkg::SYNC_WATCH;
  endsequence
  trip_clear_a: assert property (@(posedge clk) disable iff (rst)
    trip_cond |=> !ready_sync_out) else $error("trip missed");
  pass_ready_a: assert property (@(posedge clk) disable iff (rst)
    (window_clamped == 16'h0000 && state_reg != axis_sync_pkg::SYNC_FAULT)
    |=> ready_sync_out == $past(ready_in)) else $error("ready not passed");
  halt_run_a: assert property (@(posedge clk) disable iff (rst)
    !start_in |=> !profile_run) else $error("profile ran without start");
  halt_press_a: assert property (@(posedge clk) disable iff (rst)
    (profile_halt_on_pressure && pressure_active && start_in) |=> !profile_run)
    else $error("profile not paused");
  keep_run_a: assert property (@(posedge clk) disable iff (rst)
    (!profile_halt_on_pressure && start_in) |=> profile_run)
    else $error("profile stopped");
  refuse_fast_a: assert property (@(posedge clk) disable iff (rst)
    (param_write_req && bus_exchange_rate) |=> (param_write_refused && !param_write_accept))
    else $error("fast write accepted");
  override_lin_a: assert property (@(posedge clk) disable iff (rst)
    linearizer_terminal_on |=> lag_linearizing_controller)
    else $error("terminal override lost");
  out_range_a: assert property (@(posedge clk) disable iff (rst)
    (pressure_controller_output <= 16'sh2710 && pressure_controller_output >= -16'sh2710))
    else $error("pressure output out of range");
endmodule

// file: verilog/axis_sync_pkg.sv
package axis_sync_pkg;
  localparam int VALUE_WIDTH = 16;
  localparam logic [15:0] SYNC_WINDOW_MAX = 16'h2710;
  localparam logic [15:0] WINDOW_SCALE = 16'h000A;
  localparam logic [15:0] PCT_LIMIT = 16'h2710;
  localparam logic [15:0] LAG_LIMIT = 16'h7530;
  localparam logic [15:0] SYNC_WINDOW_RESET = 16'h0000;
  localparam logic [3:0] FILTER_SHIFT_RESET = 4'h3;
  localparam int CLOCK_HZ = 20000000;
  localparam int EXCHANGE_NORMAL_MS = 6;
  localparam int EXCHANGE_FAST_MS = 3;
  localparam int EXCHANGE_NORMAL_CYCLES = CLOCK_HZ / 1000 * EXCHANGE_NORMAL_MS;
  localparam int EXCHANGE_FAST_CYCLES = CLOCK_HZ / 1000 * EXCHANGE_FAST_MS;
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_SETPOINT_LAG = 3'h1,
    SEL_POSITION_OUT = 3'h3,
    SEL_PRESSURE_SET = 3'h2,
    SEL_PRESSURE_ERR = 3'h6,
    SEL_PRESSURE_OUT = 3'h7,
    SEL_MODULE_OUT = 3'h5,
    SEL_SPEED = 3'h4
  } signal_select_type;
  localparam logic [2:0] SEL_DEVIATION = 3'h0;
  typedef enum logic [1:0] {
    SYNC_IDLE = 2'h0,
    SYNC_WATCH = 2'h1,
    SYNC_FAULT = 2'h3
  } sync_state_type;
endpackage

// file: verilog/process_value_if.sv
`timescale 1ns/1ps
interface process_value_if;
  logic signed [15:0] setpoint_lag;
  logic signed [15:0] linearizer_deviation;
  logic signed [15:0] position_out;
  logic [15:0] pressure_setpoint;
  logic signed [15:0] pressure_error;
  logic signed [15:0] pressure_controller_output;
  logic signed [15:0] module_out;
  logic signed [15:0] measured_speed;
  modport source (output setpoint_lag, linearizer_deviation, position_out, pressure_setpoint,
    pressure_error, pressure_controller_output, module_out, measured_speed);
  modport sink (input setpoint_lag, linearizer_deviation, position_out, pressure_setpoint,
    pressure_error, pressure_controller_output, module_out, measured_speed);
endinterface

// file: verilog/bus_value_mux.sv
`timescale 1ns/1ps
module bus_value_mux #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] select,
  process_value_if.sink values,
  output logic [WIDTH-1:0] value_reg
);
  logic [WIDTH-1:0] value_next;
  always_comb begin
    case (select)
      3'h1: value_next = values.setpoint_lag;
      3'h3: value_next = values.position_out;
      3'h2: value_next = values.pressure_setpoint;
      3'h6: value_next = values.pressure_error;
      3'h7: value_next = values.pressure_controller_output;
      3'h5: value_next = values.module_out;
      3'h4: value_next = values.measured_speed;
      default: value_next = values.linearizer_deviation;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      value_reg <= '0;
    end else begin
      value_reg <= value_next;
    end
  end
endmodule

// file: test/plc_master.sv
`timescale 1ns/1ps
// Stand-in for the controlling master: owns enable/readiness and the start bit
module plc_master (
  input wire logic clk,
  output logic ready,
  output logic start,
  output logic valve_trigger
);
  initial begin
    ready = 1'b0;
    start = 1'b0;
    valve_trigger = 1'b0;
  end
  task automatic set_run(input logic r, input logic s);
    @(negedge clk);
    ready = r;
    start = s;
  endtask
  task automatic reenable(input int gap);
    @(negedge clk);
    ready = 1'b0;
    repeat (gap) @(negedge clk);
    ready = 1'b1;
  endtask
  task automatic stop_axis();
    @(negedge clk);
    start = 1'b0;
    repeat (2) @(negedge clk);
    valve_trigger = 1'b1;
    @(negedge clk);
    valve_trigger = 1'b0;
  endtask
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk, rst, ready_in, start_in, valve_trigger, param_write_req;
  logic [15:0] sync_window_limit, pressure_setpoint_raw, pressure_integrator_upper_limit;
  logic signed [15:0] setpoint_lag_raw, actual_lag, position_raw, pressure_error_raw;
  logic signed [15:0] pressure_p_part, pressure_i_part, module_raw, speed_raw;
  logic signed [15:0] pressure_integrator_lower_limit, linearizer_deviation;
  logic signed [15:0] pressure_controller_output;
  logic profile_halt_on_pressure, bus_exchange_rate, linearizer_bus_bit, linearizer_terminal_on;
  logic [2:0] extra_bus_signal_select_1, extra_bus_signal_select_2;
  logic ready_sync_out, profile_run, pressure_active, lag_linearizing_controller;
  logic exchange_tick, param_write_accept, param_write_refused;
  logic [31:0] bus_bytes_22_25;
  int n_errors = 0;
  int compares = 0;
  // Short exchange periods keep the run small
  axis_sync_monitor #(.NORMAL_CYCLES(10), .FAST_CYCLES(5)) u_dut (.clk, .rst, .ready_in,
    .start_in, .sync_window_limit, .filter_shift(4'h3), .setpoint_lag_raw, .actual_lag,
    .position_raw, .pressure_setpoint_raw, .pressure_error_raw, .pressure_p_part,
    .pressure_i_part, .module_raw, .speed_raw, .pressure_integrator_upper_limit,
    .pressure_integrator_lower_limit, .profile_halt_on_pressure, .bus_exchange_rate,
    .linearizer_bus_bit, .linearizer_terminal_on, .param_write_req, .extra_bus_signal_select_1,
    .extra_bus_signal_select_2, .ready_sync_out, .profile_run, .pressure_active,
    .lag_linearizing_controller, .linearizer_deviation, .pressure_controller_output,
    .bus_bytes_22_25, .exchange_tick, .param_write_accept, .param_write_refused);
  plc_master u_plc (.clk, .ready(ready_in), .start(start_in), .valve_trigger);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check1(input logic act, input logic exp);
    compares++;
    if (act !== exp) begin
      n_errors++;
      $display("Error at %0t: bit %b expected %b", $time, act, exp);
    end
  endtask
  task automatic check16(input logic [15:0] act, input logic [15:0] exp);
    compares++;
    if (act !== exp) begin
      n_errors++;
      $display("Error at %0t: value %h expected %h", $time, act, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_out(input logic exp, input int n);
    for (int k = 0; k < n && ready_sync_out !== exp; k++) @(negedge clk);
    check1(ready_sync_out, exp);
    if (ready_sync_out !== exp) print_verdict();
  endtask
  task automatic tick_gap(output int n);
    for (int k = 0; k < 40 && exchange_tick !== 1'b1; k++) @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (exchange_tick !== 1'b1 && n < 40);
    if (n == 40) begin
      n_errors++;
      $display("Error at %0t: exchange tick missing", $time);
      print_verdict();
    end
  endtask
  task automatic sc_disabled();
    actual_lag = 16'sh1388;
    u_plc.set_run(1'b1, 1'b1);
    settle(4);
    check1(ready_sync_out, 1'b1);
    u_plc.set_run(1'b0, 1'b1);
    settle(1);
    check1(ready_sync_out, 1'b0);
    u_plc.set_run(1'b1, 1'b1);
    sync_window_limit = 16'hFFFF;
    actual_lag = 16'sh7530;
    settle(8);
    check1(ready_sync_out, 1'b1);
    actual_lag = 16'sh0000;
    settle(4);
  endtask
  task automatic sc_trip();
    sync_window_limit = 16'h000A;
    actual_lag = 16'sh0064;
    settle(8);
    check16(linearizer_deviation, 16'hFF9C);
    check1(ready_sync_out, 1'b1);
    actual_lag = 16'sh0065;
    wait_out(1'b0, 6);
    actual_lag = 16'sh0000;
    settle(8);
    check1(ready_sync_out, 1'b0);
    u_plc.reenable(3);
    wait_out(1'b1, 4);
    u_plc.set_run(1'b1, 1'b0);
    actual_lag = 16'sh01F4;
    settle(8);
    check1(ready_sync_out, 1'b1);
    // Pressure takeover must be registered before start rises
    position_raw = 16'sh1388;
    settle(3);
    u_plc.set_run(1'b1, 1'b1);
    settle(8);
    check1(ready_sync_out, 1'b1);
    position_raw = 16'sh0000;
    wait_out(1'b0, 6);
    actual_lag = 16'sh0000;
    sync_window_limit = 16'h0000;
    u_plc.reenable(2);
    wait_out(1'b1, 4);
  endtask
  task automatic sc_pressure();
    position_raw = 16'sh1388;
    pressure_p_part = 16'sh0BB8;
    pressure_i_part = 16'sh0BB8;
    pressure_integrator_upper_limit = 16'h07D0;
    settle(3);
    check1(pressure_active, 1'b0);
    pressure_integrator_upper_limit = 16'h07CF;
    settle(3);
    check1(pressure_active, 1'b1);
    check1(profile_run, 1'b1);
    profile_halt_on_pressure = 1'b1;
    settle(3);
    check1(profile_run, 1'b0);
    pressure_integrator_upper_limit = 16'h07D0;
    settle(3);
    check1(profile_run, 1'b1);
    position_raw = 16'sh0000;
    pressure_p_part = 16'sh0001;
    pressure_i_part = 16'shEC78;
    settle(3);
    check1(pressure_active, 1'b0);
    pressure_integrator_lower_limit = 16'shD8F0;
    settle(3);
    check1(pressure_active, 1'b1);
    pressure_integrator_lower_limit = 16'sh0000;
    pressure_p_part = 16'sh03E8;
    pressure_i_part = 16'sh0000;
    u_plc.stop_axis();
    check1(profile_run, 1'b0);
    profile_halt_on_pressure = 1'b0;
    u_plc.set_run(1'b1, 1'b1);
  endtask
  task automatic sc_override();
    for (int k = 0; k < 4; k++) begin
      linearizer_bus_bit = k[0];
      linearizer_terminal_on = k[1];
      settle(2);
      check1(lag_linearizing_controller, k[0] | k[1]);
    end
  endtask
  task automatic sc_select();
    logic [15:0] expv [8];
    expv = '{16'hFB2E, 16'h0000, 16'h2710, 16'h2710, 16'h7530, 16'h0457, 16'hD8F0, 16'h2710};
    actual_lag = 16'sh04D2;
    // Proportional part alone overshoots, so the output clamp shows
    pressure_p_part = 16'sh2EE0;
    position_raw = 16'sh2EE0;
    pressure_setpoint_raw = 16'h2EE0;
    pressure_error_raw = 16'shD120;
    module_raw = 16'sh0457;
    speed_raw = 16'sh7918;
    for (int k = 0; k < 8; k++) begin
      extra_bus_signal_select_1 = 3'(k);
      extra_bus_signal_select_2 = 3'(k + 1);
      settle(4);
      check16(bus_bytes_22_25[15:0], expv[k]);
      check16(bus_bytes_22_25[31:16], expv[(k + 1) % 8]);
    end
    check16(pressure_controller_output, 16'h2710);
    position_raw = 16'sh0000;
    pressure_p_part = 16'sh03E8;
  endtask
  task automatic sc_rate();
    int n;
    tick_gap(n);
    check16(16'(n), 16'h000A);
    bus_exchange_rate = 1'b1;
    tick_gap(n);
    check16(16'(n), 16'h0005);
    param_write_req = 1'b1;
    settle(1);
    check1(param_write_refused, 1'b1);
    check1(param_write_accept, 1'b0);
    bus_exchange_rate = 1'b0;
    settle(1);
    check1(param_write_accept, 1'b1);
    check1(param_write_refused, 1'b0);
    param_write_req = 1'b0;
  endtask
  task automatic sc_filter();
    actual_lag = 16'sh0000;
    settle(3);
    actual_lag = 16'sh0320;
    settle(3);
    check16(linearizer_deviation, 16'hFCE0);
    setpoint_lag_raw = 16'sh0320;
    settle(2);
    check1(linearizer_deviation[15], 1'b1);
  endtask
  initial begin
    rst = 1'b1;
    {sync_window_limit, setpoint_lag_raw, actual_lag, position_raw} = '0;
    {pressure_setpoint_raw, pressure_error_raw, pressure_i_part, module_raw, speed_raw} = '0;
    pressure_p_part = 16'sh03E8;
    pressure_integrator_upper_limit = 16'h2710;
    pressure_integrator_lower_limit = 16'sh0000;
    {profile_halt_on_pressure, bus_exchange_rate, param_write_req} = '0;
    {linearizer_bus_bit, linearizer_terminal_on} = '0;
    {extra_bus_signal_select_1, extra_bus_signal_select_2} = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    sc_disabled();
    sc_trip();
    sc_pressure();
    sc_override();
    sc_select();
    sc_rate();
    sc_filter();
    print_verdict();
  end
endmodule
